// File: inc/prmc_map.svh
// prmc_map.svh: offsets, field positions, reset values and codes of the region mode checker
// assumes inclusion by bare name from the checker design file
`ifndef PRMC_MAP_SVH
`define PRMC_MAP_SVH
`define PRMC_CMD_WORD      16'h0041
`define PRMC_CMD_BUF       16'h00e9
`define PRMC_CMD_FFF       16'h0080
`define PRMC_CMD_CONFIRM   16'h00d0
`define PRMC_CMD_CLRSTAT   16'h0050
`define PRMC_CMD_ERASE     16'h0020
`define PRMC_HALF_BIT      3
`define PRMC_REGION_LSB    9
`define PRMC_ST_READY      7
`define PRMC_ST_PROGERR    4
`define PRMC_ST_VPPERR     3
`define PRMC_ST_LOCKERR    1
`define PRMC_ST_MODEERR    8
`define PRMC_ST_HALFERR    9
`define PRMC_ST_RESET      16'h0080
`define PRMC_CTRL_BYTES    512
`define PRMC_OBJ_BYTES     1024
`define PRMC_PROG_NS       40
`define PRMC_CLK_NS        5
`define PRMC_PROG_CYC      ((`PRMC_PROG_NS + `PRMC_CLK_NS - 1) / `PRMC_CLK_NS)
`endif

// File: inc/prmc_pkg.sv
// prmc_pkg: types shared by the region mode checker and its mode store
// uses no include file; prmc_map.svh serves the checker only
package prmc_pkg;
  typedef enum logic [1:0] {
    PRMC_ERASED  = 2'b00,
    PRMC_CONTROL = 2'b01,
    PRMC_OBJECT  = 2'b10
  } prmc_mode_type;
  typedef enum logic [2:0] {
    PRMC_IDLE    = 3'b000,
    PRMC_SETUP   = 3'b001,
    PRMC_LOOKUP  = 3'b010,
    PRMC_DECIDE  = 3'b011,
    PRMC_PROGRAM = 3'b100,
    PRMC_WIPE    = 3'b101
  } prmc_state_type;
endpackage

// File: inc/prmc_mode_if.sv
// prmc_mode_if: port between checker and region mode store
// assumes one clock shared by both ends
`timescale 1ns/10ps
interface prmc_mode_if #(parameter int AW = 6);
  logic                   rdEn;
  logic [AW-1:0]          rdAddr;
  prmc_pkg::prmc_mode_type rdMode;
  logic                   wrEn;
  logic [AW-1:0]          wrAddr;
  prmc_pkg::prmc_mode_type wrMode;
  modport ctrl (output rdEn, rdAddr, wrEn, wrAddr, wrMode, input rdMode);
  modport store (input rdEn, rdAddr, wrEn, wrAddr, wrMode, output rdMode);
endinterface

// File: rtl/prmc_mode_mem.sv
// prmc_mode_mem: one mode entry per programming region, registered read
// assumes reads and writes from the checker on the same clock
`timescale 1ns/10ps
module prmc_mode_mem
  import prmc_pkg::*;
#(
  parameter int DEPTH = 64,
  parameter int AW    = 6
) (
  input  wire logic clk,
  input  wire logic rst_b,
  prmc_mode_if.store mp
);
  prmc_mode_type modeArray [DEPTH];
  prmc_mode_type rdMode_ff;

  assign mp.rdMode = rdMode_ff;

  // array cleared by reset so every region starts erased
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < DEPTH; i++) begin
        modeArray[i] <= PRMC_ERASED;
      end
    end else if (mp.wrEn) begin
      modeArray[mp.wrAddr] <= mp.wrMode;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdMode_ff <= PRMC_ERASED;
    end else if (mp.rdEn) begin
      rdMode_ff <= modeArray[mp.rdAddr];
    end
  end
endmodule

// File: rtl/prmc_checker.sv
// prmc_checker: per-region program mode checker for an MLC NOR array
// assumes host writes are one-cycle strobes synchronous to clk
// Operation
// R01: region mode set automatically by zeros written on first program after erase.
// R02: both modes coexist in a block; mode changes only by block erase.
// R03: zeros only in lower half put an erased region in control mode.
// R04: control region holds 512 bytes, bit/byte/word granularity, repeat programs allowed.
// R05: control region accepts single-word, buffered and fast factory fill programs.
// R06: host keeps buffered control-region addresses in lower half, no padding needed.
// R07: zeros toward upper half of control region set bits 4,9 and abort.
// R08: any zero into upper half puts an erased region in object mode.
// R09: object region holds 1KB; unwritten words stay 0xffff.
// R10: object region accepts only buffered and fast factory fill programs.
// R11: any program to an object region sets bits 4,8 and aborts.
// R12: single-word program to upper half always fails with bits 4,8,9.
// R13: single-word lower half passes for erased/control, fails 4,8 for object.
// R14: buffered upper half: erased becomes object; control fails 4,9; object fails 4,8.
// R15: buffered lower half passes for erased/control; object fails 4,8.
// R16: programming only clears bits; ones return only by erase.
// R17: one program at a time; programming allowed during erase suspend.
// R18: locked block or bad supply aborts the program with matching error bits.
// R19: host issues setup cycle then data or confirm cycle at a device address.
// R20: host trusts status only when ready bit 7 reads one.
// R21: per-region mode kept; block erase returns its regions to erased.
//
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/10ps
`include "prmc_map.svh"
module prmc_checker
  import prmc_pkg::*;
#(
  parameter int REGION_BITS = 4,
  parameter int BLOCK_BITS  = 2,
  parameter int ADDR_W      = 24
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic [ADDR_W-1:0] busAddr,
  input  wire logic [15:0]       busWrData,
  input  wire logic              busWrStb,
  input  wire logic              busRdStb,
  output logic      [15:0]       busRdData,
  input  wire logic              blockLocked,
  input  wire logic              supplyValid,
  input  wire logic              eraseSuspended,
  input  wire logic              arrayWordZeros,
  output logic                   arrayWrEn,
  output logic      [ADDR_W-1:0] arrayWrAddr,
  output logic      [15:0]       arrayWrData,
  output logic      [1:0]        regionMode
);
  localparam int AW = BLOCK_BITS + REGION_BITS;
  // region index sits above the word offset, block index above the region index
  localparam int REG_LSB = `PRMC_REGION_LSB;
  // fixed program time stands in for the array's own completion report
  localparam logic [7:0] PROG_CYC = 8'(`PRMC_PROG_CYC);

  prmc_mode_if #(.AW(AW)) modeBus ();
  prmc_mode_mem #(.DEPTH(1 << AW), .AW(AW)) u_mem (
    .clk   (clk),
    .rst_b (rst_b),
    .mp    (modeBus)
  );

  prmc_state_type    state_ff;
  prmc_state_type    nxt_state;
  logic [15:0]       cmd_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [15:0]       data_ff;
  logic [15:0]       status_ff;
  logic [7:0]        cnt_ff;
  logic [REGION_BITS-1:0] wipeIdx_ff;
  logic              arrayWrEn_ff;
  logic [ADDR_W-1:0] arrayWrAddr_ff;
  logic [15:0]       arrayWrData_ff;
  logic [15:0]       busRdData_ff;
  logic [1:0]        regionMode_ff;
  logic              upperHalf;
  logic              isSetup;
  logic              isWord;
  logic              fault;
  logic              decideOk;
  logic              progDone;
  logic              clrReq;
  logic [2:0]        errBits;
  prmc_mode_type     newMode;
  logic [AW-1:0]     regIdx;
  logic [BLOCK_BITS-1:0] blkIdx;

  assign busRdData   = busRdData_ff;
  assign arrayWrEn   = arrayWrEn_ff;
  assign arrayWrAddr = arrayWrAddr_ff;
  assign arrayWrData = arrayWrData_ff;
  assign regionMode  = regionMode_ff;

  assign upperHalf = addr_ff[`PRMC_HALF_BIT];
  assign isWord    = (cmd_ff == `PRMC_CMD_WORD);
  assign isSetup   = (busWrData == `PRMC_CMD_WORD) || (busWrData == `PRMC_CMD_BUF) ||
                     (busWrData == `PRMC_CMD_FFF) || (busWrData == `PRMC_CMD_ERASE);
  assign regIdx    = addr_ff[REG_LSB +: AW];
  assign blkIdx    = addr_ff[REG_LSB + REGION_BITS +: BLOCK_BITS];

  // errBits = {halfErr(9), modeErr(8), progErr(4)}; newMode is the post-success mode
  always_comb begin
    errBits = 3'b000;
    newMode = modeBus.rdMode;
    if (isWord && upperHalf) begin
      errBits = 3'b111;                              // [R12]
    end else if (modeBus.rdMode == PRMC_OBJECT) begin
      errBits = 3'b011;                              // [R10] [R11] [R13] [R14] [R15]
    end else if (modeBus.rdMode == PRMC_CONTROL && upperHalf) begin
      errBits = 3'b101;                              // [R07] [R14]
    end else if (modeBus.rdMode == PRMC_ERASED) begin
      newMode = upperHalf ? PRMC_OBJECT : PRMC_CONTROL; // [R01] [R03] [R08]
    end
    // control region lower half with any method passes, repeats allowed [R04] [R05]
  end

  assign fault = blockLocked || !supplyValid;

  // clear honoured only from idle so it cannot cut into a running operation
  assign decideOk = (state_ff == PRMC_DECIDE) && !fault && (errBits == 3'b000);
  assign progDone = (state_ff == PRMC_PROGRAM) && (cnt_ff == 8'h00);
  assign clrReq   = busWrStb && (state_ff == PRMC_IDLE) && (busWrData == `PRMC_CMD_CLRSTAT);

  // two-cycle command: setup then confirm or data [R19]
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      PRMC_IDLE: begin
        if (busWrStb && isSetup) begin
          nxt_state = PRMC_SETUP;
        end
      end
      PRMC_SETUP: begin
        if (busWrStb) begin
          if (cmd_ff == `PRMC_CMD_WORD || busWrData == `PRMC_CMD_CONFIRM) begin
            nxt_state = (cmd_ff == `PRMC_CMD_ERASE) ? PRMC_WIPE : PRMC_LOOKUP;
          end else begin
            nxt_state = PRMC_IDLE;
          end
        end
      end
      PRMC_LOOKUP: nxt_state = PRMC_DECIDE;
      PRMC_DECIDE: begin
        if (fault || errBits != 3'b000) begin
          nxt_state = PRMC_IDLE;
        end else begin
          nxt_state = PRMC_PROGRAM;
        end
      end
      PRMC_PROGRAM: begin
        if (fault || cnt_ff == 8'h00) begin
          nxt_state = PRMC_IDLE;                     // [R18]
        end
      end
      PRMC_WIPE: begin
        if (wipeIdx_ff == REGION_BITS'((1 << REGION_BITS) - 1)) begin
          nxt_state = PRMC_IDLE;
        end
      end
      default: nxt_state = PRMC_IDLE;
    endcase
  end

  // single state machine means only one operation runs; suspend does not block [R17]
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= PRMC_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // command taken only from idle, so writes during a busy stretch change nothing
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_ff <= 16'h0000;
    end else if (busWrStb && state_ff == PRMC_IDLE) begin
      cmd_ff <= busWrData;
    end
  end

  // the second cycle's address names the word and region the operation acts on
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_ff <= '0;
    end else if (busWrStb && (state_ff == PRMC_IDLE || state_ff == PRMC_SETUP)) begin
      addr_ff <= busAddr;
    end
  end

  // buffered methods carry no word here; zero stands in for the buffer contents
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      data_ff <= 16'hffff;
    end else if (busWrStb && state_ff == PRMC_SETUP) begin
      data_ff <= isWord ? busWrData : 16'h0000;
    end
  end

  assign modeBus.rdEn   = (state_ff == PRMC_LOOKUP);
  assign modeBus.rdAddr = regIdx;

  // mode changes only on first program or whole-block erase [R02] [R21]
  always_comb begin
    modeBus.wrEn   = 1'b0;
    modeBus.wrAddr = regIdx;
    modeBus.wrMode = newMode;
    if (decideOk && modeBus.rdMode == PRMC_ERASED) begin
      modeBus.wrEn = 1'b1;
    end else if (state_ff == PRMC_WIPE) begin
      modeBus.wrEn   = 1'b1;
      modeBus.wrAddr = {blkIdx, wipeIdx_ff};
      modeBus.wrMode = PRMC_ERASED;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wipeIdx_ff <= '0;
    end else if (state_ff == PRMC_WIPE) begin
      wipeIdx_ff <= wipeIdx_ff + 1'b1;
    end else begin
      wipeIdx_ff <= '0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= 8'h00;
    end else if (state_ff == PRMC_DECIDE) begin
      cnt_ff <= PROG_CYC;
    end else if (state_ff == PRMC_PROGRAM && cnt_ff != 8'h00) begin
      cnt_ff <= cnt_ff - 8'h01;
    end
  end

  // status: ready bit low while busy; bits 3,1 sticky until clear command, bits 9,8,4 also rewritten at each decide without a lock or supply fault
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      status_ff <= `PRMC_ST_RESET;
    end else begin
      status_ff[`PRMC_ST_READY] <= (nxt_state == PRMC_IDLE) || (nxt_state == PRMC_SETUP);
      if (clrReq) begin
        status_ff[`PRMC_ST_HALFERR] <= 1'b0;
        status_ff[`PRMC_ST_MODEERR] <= 1'b0;
        status_ff[`PRMC_ST_PROGERR] <= 1'b0;
        status_ff[`PRMC_ST_VPPERR]  <= 1'b0;
        status_ff[`PRMC_ST_LOCKERR] <= 1'b0;
      end
      if ((state_ff == PRMC_DECIDE || state_ff == PRMC_PROGRAM) && fault) begin
        status_ff[`PRMC_ST_PROGERR] <= 1'b1;         // [R18]
        if (blockLocked) begin
          status_ff[`PRMC_ST_LOCKERR] <= 1'b1;
        end
        if (!supplyValid) begin
          status_ff[`PRMC_ST_VPPERR] <= 1'b1;
        end
      end else if (state_ff == PRMC_DECIDE && errBits != 3'b000) begin
        status_ff[`PRMC_ST_HALFERR] <= errBits[2];   // [R07] [R11] [R12]
        status_ff[`PRMC_ST_MODEERR] <= errBits[1];
        status_ff[`PRMC_ST_PROGERR] <= errBits[0];
      end else if (decideOk) begin
        // a successful start reports a clean region result [R13]
        status_ff[`PRMC_ST_HALFERR] <= 1'b0;
        status_ff[`PRMC_ST_MODEERR] <= 1'b0;
        status_ff[`PRMC_ST_PROGERR] <= 1'b0;
      end
    end
  end

  // array only gets program pulses; ones come back solely through erase [R16]
  // unwritten object words are never touched and stay erased [R09]
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      arrayWrEn_ff <= 1'b0;
    end else begin
      arrayWrEn_ff <= progDone && !fault;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      arrayWrAddr_ff <= '0;
      arrayWrData_ff <= 16'hffff;
    end else begin
      arrayWrAddr_ff <= addr_ff;
      arrayWrData_ff <= data_ff;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busRdData_ff <= 16'h0000;
    end else begin
      busRdData_ff <= busRdStb ? status_ff : 16'h0000;   // [R20]
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      regionMode_ff <= 2'b00;
    end else begin
      regionMode_ff <= modeBus.rdMode;
    end
  end
endmodule

// File: bench/prmc_checker_sva.sv
// prmc_checker_sva: port-level checks of the region mode checker
// assumes one clock and the async active-low reset of the top module
`timescale 1ns/10ps
module prmc_checker_sva #(
  parameter int ADDR_W = 24
) (
  input wire logic              clk,
  input wire logic              rst_b,
  input wire logic [ADDR_W-1:0] busAddr,
  input wire logic [15:0]       busWrData,
  input wire logic              busWrStb,
  input wire logic              busRdStb,
  input wire logic [15:0]       busRdData,
  input wire logic              blockLocked,
  input wire logic              supplyValid,
  input wire logic              arrayWrEn,
  input wire logic [ADDR_W-1:0] arrayWrAddr,
  input wire logic [1:0]        regionMode
);
  logic [5:0] sinceWr_ff;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // saturates so a long idle stretch never wraps into the legal window
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) sinceWr_ff <= 6'h00;
    else if (busWrStb) sinceWr_ff <= 6'h00;
    else if (sinceWr_ff != 6'h3f) sinceWr_ff <= sinceWr_ff + 6'h01;
  end
  sequence upper_word_seq;
    busWrStb && busWrData == 16'h0041 && busAddr[3] ##1 busWrStb;
  endsequence
  sequence no_write_seq;
    (!arrayWrEn)[*8] ##1 (!arrayWrEn)[*8];
  endsequence
  read_slot_a: assert property (!$past(busRdStb) |-> busRdData == 16'h0000)
    else $error("read data outside its slot");
  pulse_once_a: assert property (arrayWrEn |=> !arrayWrEn)
    else $error("array write longer than one cycle");
  write_guard_a: assert property (arrayWrEn |-> $past(supplyValid) && !$past(blockLocked))
    else $error("array write while locked or unsupplied");
  write_delay_a: assert property (arrayWrEn |-> sinceWr_ff inside {[6'h03:6'h14]})
    else $error("array write out of step with host cycles");
  mode_code_a: assert property (regionMode != 2'b11)
    else $error("undefined region mode");
  upper_word_a: assert property (upper_word_seq |=> no_write_seq)
    else $error("upper half single word reached the array");
  object_lock_a: assert property (arrayWrEn |-> regionMode != 2'b10)
    else $error("object region written again");
  upper_ctrl_a: assert property (arrayWrEn && arrayWrAddr[3] |-> regionMode == 2'b00)
    else $error("upper half written outside erased region");
endmodule
bind prmc_checker prmc_checker_sva #(.ADDR_W(ADDR_W)) i_prmc_checker_sva (.clk, .rst_b, .busAddr, .busWrData,
  .busWrStb, .busRdStb, .busRdData, .blockLocked, .supplyValid, .arrayWrEn, .arrayWrAddr, .regionMode);

// File: bench/prmc_host.sv
// prmc_host: host controller model issuing one-cycle bus strobes
// assumes every task is entered just after a rising clk edge
`timescale 1ns/10ps
module prmc_host (
  input  wire logic        clk,
  output logic      [23:0] busAddr,
  output logic      [15:0] busWrData,
  output logic             busWrStb,
  output logic             busRdStb,
  input  wire logic [15:0] busRdData
);
  initial begin
    busAddr = 24'h000000;
    busWrData = 16'h0000;
    busWrStb = 1'b0;
    busRdStb = 1'b0;
  end
  // setup then data or confirm back to back at one address
  task automatic send(input logic [23:0] a, input logic [15:0] c, input logic [15:0] d, input bit pair);
    busAddr <= a;
    busWrData <= c;
    busWrStb <= 1'b1;
    @(posedge clk);
    if (pair) begin
      busWrData <= d;
      @(posedge clk);
    end
    busWrStb <= 1'b0;
    busWrData <= ~busWrData;
    @(posedge clk);
  endtask
  // status trusted only once the ready bit reads one
  task automatic poll(output logic [15:0] st);
    st = 16'h0000;
    for (int n = 0; n < 60 && st[7] !== 1'b1; n++) begin
      busRdStb <= 1'b1;
      @(posedge clk);
      busRdStb <= 1'b0;
      @(posedge clk);
      st = busRdData;
    end
  endtask
endmodule

// File: bench/prmc_checker_tb.sv
// prmc_checker_tb: self-checking bench for the region mode checker
// assumes the host model drives the bus; the array side is only watched
`timescale 1ns/10ps
module prmc_checker_tb;
  import prmc_pkg::*;
  typedef struct packed {
    logic [15:0] cmd;
    logic [23:0] addr;
    logic [15:0] data;
    logic [15:0] expSt;
    logic [1:0]  expMode;
  } prmc_row_type;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        blockLocked = 1'b0;
  logic        supplyValid = 1'b1;
  logic        eraseSuspended = 1'b0;
  logic [23:0] busAddr, arrayWrAddr, lastAddr;
  logic [15:0] busWrData, busRdData, arrayWrData, lastData, st;
  logic        busWrStb, busRdStb, arrayWrEn;
  logic [1:0]  regionMode;
  int          wrCount, failCount, checked, cycles, n;
  // mode shown is the one looked up before the command acts
  prmc_row_type rows [10] = '{
    '{16'h0041, 24'h000000, 16'h1234, 16'h0080, 2'b00},
    '{16'h0041, 24'h000008, 16'h5678, 16'h0390, 2'b01},
    '{16'h00e9, 24'h000008, 16'h00d0, 16'h0290, 2'b01},
    '{16'h00e9, 24'h000000, 16'h00d0, 16'h0080, 2'b01},
    '{16'h0080, 24'h000000, 16'h00d0, 16'h0080, 2'b01},
    '{16'h00e9, 24'h000208, 16'h00d0, 16'h0080, 2'b00},
    '{16'h0041, 24'h000200, 16'h9abc, 16'h0190, 2'b10},
    '{16'h00e9, 24'h000200, 16'h00d0, 16'h0190, 2'b10},
    '{16'h0080, 24'h000208, 16'h00d0, 16'h0190, 2'b10},
    '{16'h0041, 24'h000408, 16'h4321, 16'h0390, 2'b00}};
  always #2.5 clk = ~clk;
  prmc_host i_prmc_host (.clk, .busAddr, .busWrData, .busWrStb, .busRdStb, .busRdData);
  prmc_checker i_prmc_checker (.clk, .rst_b, .busAddr, .busWrData, .busWrStb, .busRdStb, .busRdData,
    .blockLocked, .supplyValid, .eraseSuspended, .arrayWordZeros(1'b0), .arrayWrEn, .arrayWrAddr,
    .arrayWrData, .regionMode);
  always @(posedge clk) begin
    cycles++;
    if (arrayWrEn === 1'b1) begin
      wrCount++;
      lastAddr <= arrayWrAddr;
      lastData <= arrayWrData;
    end
    if (cycles == 5000) begin
      failCount++;
      print_verdict();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      failCount++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, failCount);
    if (failCount == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // sticky errors are cleared first so each result stands alone
  task automatic run(input logic [23:0] a, input logic [15:0] c, input logic [15:0] d);
    i_prmc_host.send(24'h000000, 16'h0050, 16'h0000, 1'b0);
    n = wrCount;
    i_prmc_host.send(a, c, d, 1'b1);
    repeat (2) @(posedge clk);
    i_prmc_host.poll(st);
    repeat (2) @(posedge clk);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    check(arrayWrData, 16'hffff);
    i_prmc_host.poll(st);
    check(st, 16'h0080);
    foreach (rows[i]) begin
      run(rows[i].addr, rows[i].cmd, rows[i].data);
      check(st, rows[i].expSt);
      check({14'h0000, regionMode}, {14'h0000, rows[i].expMode});
      check(16'(wrCount - n), {15'h0000, rows[i].expSt == 16'h0080});
      if (rows[i].expSt == 16'h0080) begin
        check(lastAddr[15:0], rows[i].addr[15:0]);
        check(lastData, rows[i].cmd == 16'h0041 ? rows[i].data : 16'h0000);
      end
    end
    run(24'h000000, 16'h0020, 16'h00d0);
    run(24'h000208, 16'h00e9, 16'h00d0);
    check(st, 16'h0080);
    check({14'h0000, regionMode}, 16'h0000);
    i_prmc_host.send(24'h000208, 16'h0041, 16'h1111, 1'b1);
    i_prmc_host.poll(st);
    check(st, 16'h0390);
    i_prmc_host.send(24'h000000, 16'h0041, 16'h2222, 1'b1);
    i_prmc_host.poll(st);
    check(st, 16'h0080);
    eraseSuspended <= 1'b1;
    run(24'h000600, 16'h0041, 16'habcd);
    check(st, 16'h0080);
    eraseSuspended <= 1'b0;
    blockLocked <= 1'b1;
    run(24'h000800, 16'h00e9, 16'h00d0);
    check(st & 16'h000a, 16'h0002);
    blockLocked <= 1'b0;
    supplyValid <= 1'b0;
    run(24'h000a00, 16'h0080, 16'h00d0);
    check(st & 16'h000a, 16'h0008);
    check(16'(wrCount - n), 16'h0000);
    supplyValid <= 1'b1;
    rst_b <= 1'b0;
    @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    i_prmc_host.poll(st);
    check(st, 16'h0080);
    print_verdict();
  end
endmodule
